// file: verilog/rcia_top.sv
// Reset cause capture, reset pin control and interrupt acknowledge decode.
//
// Contract
// [RULE_01] Reading voltage status acknowledges low-voltage, hot, low-battery, high-voltage, overvoltage.
// [RULE_02] Reading bus transceiver status acknowledges bus-driver overtemperature.
// [RULE_03] Reading high-side status acknowledges high-side overtemperature.
// [RULE_04] Reading low-side status acknowledges low-side overtemperature.
// [RULE_05] Reading hall supply register acknowledges hall supply overtemperature.
// [RULE_06] After acknowledge an interrupt re-raises only on a fresh condition edge.
// [RULE_07] Reset pin driven low while any internal reset condition exists.
// [RULE_08] Reset pin level is monitored continuously for external resets.
// [RULE_09] Reset pin held low a fixed stretch after the last condition ends.
// [RULE_10] Entering reset mode defaults registers except reset cause and wake source.
// [RULE_11] Power-on flag set on low main supply or die power-up.
// [RULE_12] Core regulator undervoltage raises a core undervoltage reset.
// [RULE_13] I/O undervoltage raises a reset and shuts down the core regulator.
// [RULE_14] Wake-up event in sleep enters reset and records wake reset cause.
// [RULE_15] Reset pin low longer than filter time records an external reset.
// [RULE_16] Incorrect watchdog service generates and records a watchdog reset.
// [RULE_17] Cause register 8 bits at 0x15, top two bits zero, six flags.
// [RULE_18] Offsets map at base 0x0200 blocking and 0x300 non-blocking.
// [RULE_19] Reading cause register returns flags then clears; writes do nothing.
// [RULE_20] Undervoltage flags suppressed while power-on or wake flag is set.
// [RULE_21] Several cause flags accumulate until the next read clears them.
`timescale 1ns/1ps
`default_nettype none
module rcia_top
	import rcia_pkg::*;
#(
	parameter int STRETCH_CYC = RCIA_STRETCH_CYC,
	parameter int FILTER_CYC  = RCIA_FILTER_CYC
) (
	// Clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  SYS_RST,
	// Register access
	input  wire logic [15:0]           BUS_ADDR,
	input  wire logic                  BUS_RD,
	output logic      [7:0]            BUS_RDATA,
	output logic                       BUS_RVALID,
	// Reset pin, open drain
	input  wire logic                  RST_PIN_I,
	output logic                       RST_PIN_O,
	output logic                       RST_PIN_OE,
	// Reset sources
	input  wire logic                  POR_COND,
	input  wire logic                  CORE_UV_COND,
	input  wire logic                  IO_UV_COND,
	input  wire logic                  WAKE_EVENT,
	input  wire logic                  SLEEP_MODE,
	input  wire logic                  WDOG_FAULT,
	// Interrupt conditions and state
	input  wire logic [RCIA_IRQ_N-1:0] IRQ_COND,
	output logic      [RCIA_IRQ_N-1:0] IRQ_PEND,
	// Mode outputs
	output logic                       RESET_MODE,
	output logic                       CORE_REG_OFF
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	localparam int SYNC_W = RCIA_IRQ_N + 5;
	// The reset pin idles high, so its synchroniser must not show a low after reset.
	localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << RCIA_IRQ_N;

	initial begin
		if (STRETCH_CYC < 1 || STRETCH_CYC >= (1 << RCIA_CNT_W))
			$error("stretch count does not fit the counter");
		// The pin synchroniser shows our own release two cycles late.
		if (FILTER_CYC < 3 || FILTER_CYC >= (1 << RCIA_CNT_W))
			$error("filter count must exceed the synchroniser lag and fit the counter");
	end

	localparam logic [RCIA_CNT_W-1:0] STRETCH_LOAD = RCIA_CNT_W'(STRETCH_CYC);
	localparam logic [RCIA_CNT_W-1:0] FILTER_LIM   = RCIA_CNT_W'(FILTER_CYC);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]            cause;
		logic [7:0]            rdata;
		logic                  rvalid;
		logic [RCIA_CNT_W-1:0] stretch;
		logic                  drive;
		logic [RCIA_CNT_W-1:0] filt;
		logic                  ext_seen;
		logic                  rst_mode;
	} rcia_state_t;

	rcia_state_t st_ff;
	rcia_state_t nxt_st;

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [SYNC_W-1:0]     sync_q;
	logic [RCIA_IRQ_N-1:0] irq_cond_s;
	logic                  pin_s;
	logic                  por_s;
	logic                  core_uv_s;
	logic                  io_uv_s;
	logic                  wake_s;

	rcia_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_IDLE)
	) u_sync (
		.clk (SYS_CLK),
		.rst (SYS_RST),
		.d   ({WAKE_EVENT, IO_UV_COND, CORE_UV_COND, POR_COND, RST_PIN_I, IRQ_COND}),
		.q   (sync_q)
	);

	assign irq_cond_s = sync_q[RCIA_IRQ_N-1:0];
	assign pin_s      = sync_q[RCIA_IRQ_N];     // [RULE_08]
	assign por_s      = sync_q[RCIA_IRQ_N+1];
	assign core_uv_s  = sync_q[RCIA_IRQ_N+2];
	assign io_uv_s    = sync_q[RCIA_IRQ_N+3];
	assign wake_s     = sync_q[RCIA_IRQ_N+4];

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic       win_hit;
	logic [7:0] ofs;
	logic       rd_cause;
	logic       rd_volt;
	logic       rd_busx;
	logic       rd_hs;
	logic       rd_ls;
	logic       rd_hall;

	assign ofs = BUS_ADDR[7:0];

	always_comb begin
		win_hit = 1'b0;
		if ((BUS_ADDR & RCIA_WINDOW_MASK) == RCIA_BLOCKING_BASE) begin // [RULE_18]
			win_hit = 1'b1;
		end else if ((BUS_ADDR & RCIA_WINDOW_MASK) == RCIA_NONBLOCK_BASE) begin // [RULE_18]
			win_hit = 1'b1;
		end
	end

	always_comb begin
		rd_cause = 1'b0;
		rd_volt  = 1'b0;
		rd_busx  = 1'b0;
		rd_hs    = 1'b0;
		rd_ls    = 1'b0;
		rd_hall  = 1'b0;
		if (!(BUS_RD && win_hit)) begin
			rd_cause = 1'b0;
		end else if (ofs == RCIA_OFS_CAUSE) begin
			rd_cause = 1'b1;
		end else if (ofs == RCIA_OFS_VOLT) begin
			rd_volt = 1'b1;
		end else if (ofs == RCIA_OFS_BUS_XCVR) begin
			rd_busx = 1'b1;
		end else if (ofs == RCIA_OFS_HIGH_SIDE) begin
			rd_hs = 1'b1;
		end else if (ofs == RCIA_OFS_LOW_SIDE) begin
			rd_ls = 1'b1;
		end else if (ofs == RCIA_OFS_HALL) begin
			rd_hall = 1'b1;
		end
	end

	// ****************************************************************
	// Interrupt acknowledge
	// ****************************************************************
	logic [RCIA_IRQ_N-1:0] irq_ack;
	logic                  mode_entry;

	always_comb begin
		irq_ack                   = '0;
		irq_ack[RCIA_IRQ_LOWV]    = rd_volt;  // [RULE_01]
		irq_ack[RCIA_IRQ_REGHOT]  = rd_volt;  // [RULE_01]
		irq_ack[RCIA_IRQ_LOWBAT]  = rd_volt;  // [RULE_01]
		irq_ack[RCIA_IRQ_HIGHV]   = rd_volt;  // [RULE_01]
		irq_ack[RCIA_IRQ_REGOV]   = rd_volt;  // [RULE_01]
		irq_ack[RCIA_IRQ_BUSOT]   = rd_busx;  // [RULE_02]
		irq_ack[RCIA_IRQ_HIGH_SIDE_OVERTEMP_IRQ]    = rd_hs;    // [RULE_03]
		irq_ack[RCIA_IRQ_LOW_SIDE_OVERTEMP_IRQ]    = rd_ls;    // [RULE_04]
		irq_ack[RCIA_IRQ_HALLOT]  = rd_hall;  // [RULE_05]
	end

	// Pending interrupts are ordinary registers, so reset mode wipes them.
	assign mode_entry = nxt_st.rst_mode & ~st_ff.rst_mode; // [RULE_10]

	rcia_irq_rearm #(
		.N (RCIA_IRQ_N)
	) u_irq (
		.clk  (SYS_CLK),
		.rst  (SYS_RST),
		.init (mode_entry),
		.cond (irq_cond_s),
		.ack  (irq_ack),
		.pend (IRQ_PEND)
	);

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	logic       wake_rst;
	logic       int_cond;
	logic       pin_low_ext;
	logic       ext_evt;
	logic [7:0] cause_set;
	logic [7:0] cause_view;

	assign wake_rst    = SLEEP_MODE & wake_s; // [RULE_14]
	assign int_cond    = por_s | core_uv_s | io_uv_s | wake_rst | WDOG_FAULT; // [RULE_07]
	// Our own drive also pulls the pin low, so only count lows we are not causing.
	assign pin_low_ext = ~pin_s & ~st_ff.drive;
	assign ext_evt     = pin_low_ext & (st_ff.filt == FILTER_LIM) & ~st_ff.ext_seen; // [RULE_15]

	always_comb begin
		cause_set                = 8'h00;
		cause_set[RCIA_POR_BIT]  = por_s;      // [RULE_11]
		cause_set[RCIA_CUV_BIT]  = core_uv_s;  // [RULE_12]
		cause_set[RCIA_IOUV_BIT] = io_uv_s;    // [RULE_13]
		cause_set[RCIA_WAKE_BIT] = wake_rst;   // [RULE_14]
		cause_set[RCIA_EXT_BIT]  = ext_evt;    // [RULE_15]
		cause_set[RCIA_WDOG_BIT] = WDOG_FAULT; // [RULE_16]
	end

	// Undervoltage flags are hidden, not erased, so the stored history stays intact.
	always_comb begin
		cause_view = st_ff.cause & RCIA_CAUSE_USED; // [RULE_17]
		if (st_ff.cause[RCIA_POR_BIT] || st_ff.cause[RCIA_WAKE_BIT]) begin
			cause_view[RCIA_CUV_BIT]  = 1'b0; // [RULE_20]
			cause_view[RCIA_IOUV_BIT] = 1'b0; // [RULE_20]
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;

		// New events win over the read clear; flags pile up until read.
		nxt_st.cause = (cause_set | (st_ff.cause & ~{8{rd_cause}})) & RCIA_CAUSE_USED; // [RULE_19] [RULE_21]

		nxt_st.rvalid = BUS_RD;
		if (rd_cause) begin
			nxt_st.rdata = cause_view; // [RULE_19]
		end else if (BUS_RD) begin
			nxt_st.rdata = 8'h00;
		end

		if (int_cond) begin
			nxt_st.stretch = STRETCH_LOAD; // [RULE_09]
		end else if (st_ff.stretch != '0) begin
			nxt_st.stretch = st_ff.stretch - 1'b1; // [RULE_09]
		end
		nxt_st.drive = int_cond | (nxt_st.stretch != '0); // [RULE_07]

		if (!pin_low_ext) begin
			nxt_st.filt     = '0;
			nxt_st.ext_seen = 1'b0;
		end else if (st_ff.filt != FILTER_LIM) begin
			nxt_st.filt = st_ff.filt + 1'b1; // [RULE_15]
		end else if (ext_evt) begin
			nxt_st.ext_seen = 1'b1;
		end

		nxt_st.rst_mode = nxt_st.drive | ~pin_s; // [RULE_10]
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			st_ff       <= '0;
			st_ff.cause <= RCIA_CAUSE_RESET; // [RULE_11]
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign BUS_RDATA    = st_ff.rdata;
	assign BUS_RVALID   = st_ff.rvalid;
	assign RST_PIN_O    = 1'b0;
	assign RST_PIN_OE   = st_ff.drive;
	assign RESET_MODE   = st_ff.rst_mode;
	assign CORE_REG_OFF = io_uv_s; // [RULE_13]

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_pin_drive: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_07]
		int_cond |=> RST_PIN_OE) else $error("pin not driven during reset condition");
	a_stretch_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_09]
		(int_cond ##1 !int_cond) |-> RST_PIN_OE ##1 RST_PIN_OE)
		else $error("pin released before stretch");
	a_stretch_end: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_09]
		(!int_cond && st_ff.stretch == 1) |=> !RST_PIN_OE) else $error("pin held too long");
	a_ext_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_15]
		ext_evt |=> st_ff.cause[RCIA_EXT_BIT]) else $error("external reset not recorded");
	a_ext_filter: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_15]
		(pin_s ##1 !pin_s && !st_ff.drive) |-> !ext_evt) else $error("short low flagged");
	a_cause_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_19]
		(rd_cause && cause_set == 8'h00) |=> st_ff.cause == 8'h00)
		else $error("cause not cleared by read");
	a_cause_rdata: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_19]
		rd_cause |=> (BUS_RVALID && BUS_RDATA == $past(cause_view)))
		else $error("cause read data wrong");
	a_top_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_17]
		BUS_RVALID |-> BUS_RDATA[7:6] == 2'b00) else $error("reserved bits set");
	a_uv_mask: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_20]
		(rd_cause && (st_ff.cause[RCIA_POR_BIT] || st_ff.cause[RCIA_WAKE_BIT]))
		|=> BUS_RDATA[2:1] == 2'b00) else $error("undervoltage flags not masked");
	a_flag_keep: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_21]
		(!rd_cause && st_ff.cause[RCIA_WDOG_BIT]) |=> st_ff.cause[RCIA_WDOG_BIT])
		else $error("cause flag lost without read");
	a_wake_rec: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_14]
		wake_rst |=> (st_ff.cause[RCIA_WAKE_BIT] && RST_PIN_OE)) else $error("wake reset lost");
	a_core_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RULE_13]
		io_uv_s |-> CORE_REG_OFF) else $error("core regulator not shut down");

	c_ext_reset: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) ext_evt);
	c_release: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) $fell(RST_PIN_OE));
	c_multi_cause: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		rd_cause && st_ff.cause[RCIA_WDOG_BIT] && st_ff.cause[RCIA_EXT_BIT]);
	c_vsr_ack: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		rd_volt && IRQ_PEND[RCIA_IRQ_LOWV]);

endmodule : rcia_top
`default_nettype wire

// file: verilog/rcia_pkg.sv
// Shared constants for the reset cause capture and interrupt acknowledge block.
package rcia_pkg;

	// ****************************************************************
	// Address windows and register offsets
	// ****************************************************************
	localparam logic [15:0] RCIA_BLOCKING_BASE = 16'h0200;
	localparam logic [15:0] RCIA_NONBLOCK_BASE = 16'h0300;
	localparam logic [15:0] RCIA_WINDOW_MASK   = 16'hff00;
	localparam logic [7:0]  RCIA_OFS_CAUSE     = 8'h15;
	localparam logic [7:0]  RCIA_OFS_VOLT      = 8'h08;
	localparam logic [7:0]  RCIA_OFS_BUS_XCVR  = 8'h09;
	localparam logic [7:0]  RCIA_OFS_HIGH_SIDE = 8'h0a;
	localparam logic [7:0]  RCIA_OFS_LOW_SIDE  = 8'h0b;
	localparam logic [7:0]  RCIA_OFS_HALL      = 8'h0c;

	// ****************************************************************
	// Reset cause field positions and reset value
	// ****************************************************************
	localparam int RCIA_POR_BIT  = 0;
	localparam int RCIA_CUV_BIT  = 1;
	localparam int RCIA_IOUV_BIT = 2;
	localparam int RCIA_WAKE_BIT = 3;
	localparam int RCIA_EXT_BIT  = 4;
	localparam int RCIA_WDOG_BIT = 5;
	localparam logic [7:0] RCIA_CAUSE_RESET = 8'h01;
	localparam logic [7:0] RCIA_CAUSE_USED  = 8'h3f;

	// ****************************************************************
	// Interrupt source positions
	// ****************************************************************
	localparam int RCIA_IRQ_N        = 9;
	localparam int RCIA_IRQ_LOWV     = 0;
	localparam int RCIA_IRQ_REGHOT   = 1;
	localparam int RCIA_IRQ_LOWBAT   = 2;
	localparam int RCIA_IRQ_HIGHV    = 3;
	localparam int RCIA_IRQ_REGOV    = 4;
	localparam int RCIA_IRQ_BUSOT    = 5;
	localparam int RCIA_IRQ_HIGH_SIDE_OVERTEMP_IRQ     = 6;
	localparam int RCIA_IRQ_LOW_SIDE_OVERTEMP_IRQ     = 7;
	localparam int RCIA_IRQ_HALLOT   = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int RCIA_CNT_W           = 16;
	localparam int RCIA_CLK_PERIOD_NS   = 10;
	localparam int RCIA_STRETCH_NS      = 1000;
	localparam int RCIA_FILTER_NS       = 500;
	localparam int RCIA_STRETCH_CYC_RAW = RCIA_STRETCH_NS / RCIA_CLK_PERIOD_NS;
	localparam int RCIA_STRETCH_CYC     = (RCIA_STRETCH_CYC_RAW < 1) ? 1 : RCIA_STRETCH_CYC_RAW;
	localparam int RCIA_FILTER_CYC_RAW  =
		(RCIA_FILTER_NS + RCIA_CLK_PERIOD_NS - 1) / RCIA_CLK_PERIOD_NS;
	localparam int RCIA_FILTER_CYC      = (RCIA_FILTER_CYC_RAW < 1) ? 1 : RCIA_FILTER_CYC_RAW;

endpackage : rcia_pkg

// file: verilog/rcia_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
`default_nettype none
module rcia_sync #(
	parameter int           W       = 1,
	// Value held in reset; give each input its idle level so no false edge follows.
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rcia_sync_t;

	rcia_sync_t st_ff;
	rcia_sync_t nxt_st;

	initial begin
		if (W < 1) $error("rcia_sync width must be at least one");
	end

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= {RST_VAL, RST_VAL};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule : rcia_sync
`default_nettype wire

// file: verilog/rcia_irq_rearm.sv
// Edge-triggered interrupt pending bits with read acknowledge.
`timescale 1ns/1ps
`default_nettype none
module rcia_irq_rearm #(
	parameter int N = 9
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Control
	input  wire logic         init,
	input  wire logic [N-1:0] cond,
	input  wire logic [N-1:0] ack,
	// Status
	output logic      [N-1:0] pend
);
	typedef struct packed {
		logic [N-1:0] prev;
		logic [N-1:0] pend;
	} rcia_irq_t;

	rcia_irq_t    st_ff;
	rcia_irq_t    nxt_st;
	logic [N-1:0] rise;
	logic [N-1:0] nxt_pend;

	initial begin
		if (N < 1) $error("rcia_irq_rearm needs at least one source");
	end

	// A held condition never re-raises; only a fresh rising edge does, and it
	// beats an acknowledge landing in the same cycle.
	for (genvar i = 0; i < N; i++) begin : g_src
		assign rise[i]     = cond[i] & ~st_ff.prev[i];
		assign nxt_pend[i] = rise[i] | (st_ff.pend[i] & ~ack[i] & ~init); // [RULE_06]
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.prev = cond;
		nxt_st.pend = nxt_pend;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pend = st_ff.pend;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	for (genvar j = 0; j < N; j++) begin : g_chk
		a_irq_rise_sets: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
			rise[j] |=> pend[j]) else $error("edge did not raise pending");
		a_irq_ack_clears: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
			(ack[j] && !rise[j] && pend[j]) |=> !pend[j]) else $error("ack did not clear");
		a_irq_no_retrig: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
			(cond[j] && st_ff.prev[j] && !pend[j]) |=> !pend[j])
			else $error("held condition re-raised");
	end
	c_irq_rearm: cover property (@(posedge clk) disable iff (rst)
		pend[0] ##1 !pend[0] ##[1:20] pend[0]);
endmodule : rcia_irq_rearm
`default_nettype wire

// file: bench/rcia_host_model.sv
// Host side of the shared open-drain reset line, with its pull-up.
`timescale 1ns/1ps
`default_nettype none
module rcia_host_model (
	// Device side of the line
	input  wire logic dev_o,
	input  wire logic dev_oe,
	// Host request to hold the line low
	input  wire logic pull_req,
	// Resolved line level
	output logic      pin_level
);
	// The pull-up wins only while neither party pulls the line down.
	assign pin_level = !((dev_oe && !dev_o) || pull_req);
endmodule : rcia_host_model
`default_nettype wire

// file: bench/rcia_top_tb.sv
// Self-checking bench for the reset cause capture and interrupt acknowledge block.
`timescale 1ns/1ps
`default_nettype none
module rcia_top_tb
	import rcia_pkg::*;
;
	localparam int STRETCH = 4;
	localparam int FILTER  = 3;
	logic        sys_clk, sys_rst, bus_rd, bus_rvalid, rst_pin, rst_o, rst_oe, host_pull;
	logic        por, cuv, iouv, wake, sleep, wdog, reset_mode, core_off;
	logic [15:0] bus_addr;
	logic [7:0]  bus_rdata;
	logic [8:0]  irq_cond, irq_pend;
	logic [31:0] seed;
	int          fail_count = 0;
	int          compares = 0;
	int          cyc = 0;

	rcia_top #(.STRETCH_CYC(STRETCH), .FILTER_CYC(FILTER)) uut (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .BUS_ADDR(bus_addr), .BUS_RD(bus_rd),
		.BUS_RDATA(bus_rdata), .BUS_RVALID(bus_rvalid), .RST_PIN_I(rst_pin),
		.RST_PIN_O(rst_o), .RST_PIN_OE(rst_oe), .POR_COND(por), .CORE_UV_COND(cuv),
		.IO_UV_COND(iouv), .WAKE_EVENT(wake), .SLEEP_MODE(sleep), .WDOG_FAULT(wdog),
		.IRQ_COND(irq_cond), .IRQ_PEND(irq_pend), .RESET_MODE(reset_mode),
		.CORE_REG_OFF(core_off));
	rcia_host_model host (.dev_o(rst_o), .dev_oe(rst_oe), .pull_req(host_pull),
		.pin_level(rst_pin));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// The whole sequence needs well under two thousand cycles.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			stop_test();
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic logic [7:0] view(input logic [7:0] c);
		if (c[RCIA_POR_BIT] || c[RCIA_WAKE_BIT]) begin
			c[RCIA_CUV_BIT]  = 1'b0;
			c[RCIA_IOUV_BIT] = 1'b0;
		end
		return c;
	endfunction : view

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1

	task automatic cycles(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cycles

	// Called at a falling edge; the answer is looked at on the next falling edge, half a cycle after the taking edge.
	// One idle cycle follows, so a second call never raises the strobe it just lowered.
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		bus_addr = a;
		bus_rd   = 1'b1;
		@(negedge sys_clk);
		bus_rd   = 1'b0;
		chk1(bus_rvalid, 1'b1);
		chk8(bus_rdata, exp);
		@(negedge sys_clk);
	endtask : rd

	task automatic stop_test();
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		int         n;
		logic [7:0] raw;
		logic [7:0] ofs;
		logic [31:0] pat;
		sys_rst  = 1'b1;
		bus_addr = 16'h0000;
		irq_cond = 9'h000;
		seed     = 32'd21;
		{por, cuv, iouv, wake, sleep, wdog, host_pull, bus_rd} = 8'h00;
		cycles(3);
		sys_rst = 1'b0;
		rd(16'h0215, RCIA_CAUSE_RESET);
		chk1(reset_mode, 1'b0);
		chk1(rst_oe, 1'b0);
		rd(16'h0215, 8'h00);
		// A pending interrupt must not survive the watchdog reset that follows.
		irq_cond[RCIA_IRQ_LOWBAT] = 1'b1;
		cycles(4);
		chk1(irq_pend[RCIA_IRQ_LOWBAT], 1'b1);
		wdog = 1'b1;
		cycles(1);
		wdog = 1'b0;
		n = 0;
		while (rst_oe === 1'b1 && n < 50) begin
			if (n == 2) chk1(reset_mode, 1'b1);
			n = n + 1;
			cycles(1);
		end
		chk8(8'(n), 8'(STRETCH));
		chk1(irq_pend[RCIA_IRQ_LOWBAT], 1'b0);
		irq_cond = 9'h000;
		cycles(6);
		rd(16'h0415, 8'h00);
		rd(16'h0315, 8'h20);
		// Two fixed corners, then random mixes of internal causes.
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			pat  = (i == 0) ? 32'h0000_0003 : (i == 1) ? 32'h0000_007f : seed;
			raw  = {2'b00, pat[2], 1'b0, pat[3] & pat[4], pat[1], pat[0], &pat[6:5]};
			{sleep, wake, wdog, iouv, cuv} = pat[4:0];
			por = &pat[6:5];
			cycles(4);
			chk1(core_off, pat[1]);
			chk1(rst_oe, raw != 8'h00);
			{por, cuv, iouv, wake, sleep, wdog} = 6'h00;
			cycles(STRETCH + 10);
			rd({7'h01, pat[8], RCIA_OFS_CAUSE}, view(raw));
			rd(16'h0215, 8'h00);
		end
		host_pull = 1'b1;
		cycles(FILTER + 8);
		host_pull = 1'b0;
		cycles(6);
		rd(16'h0215, 8'h10);
		host_pull = 1'b1;
		cycles(2);
		host_pull = 1'b0;
		cycles(6);
		rd(16'h0215, 8'h00);
		for (int b = 0; b < RCIA_IRQ_N; b++) begin
			ofs = (b < 5) ? RCIA_OFS_VOLT : RCIA_OFS_VOLT + 8'(b - 4);
			irq_cond[b] = 1'b1;
			cycles(4);
			rd(16'h0215, 8'h00);
			chk1(irq_pend[b], 1'b1);
			rd({8'h02, ofs}, 8'h00);
			chk1(irq_pend[b], 1'b0);
			cycles(4);
			chk1(irq_pend[b], 1'b0);
			irq_cond[b] = 1'b0;
			cycles(4);
			irq_cond[b] = 1'b1;
			cycles(4);
			chk1(irq_pend[b], 1'b1);
			rd({8'h03, ofs}, 8'h00);
			chk1(irq_pend[b], 1'b0);
			irq_cond[b] = 1'b0;
		end
		stop_test();
	end
endmodule : rcia_top_tb
`default_nettype wire
